//--- flash_block_erase_protect.sv
`timescale 1ns/100ps
module flash_block_erase_protect
  import flash_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rd_req_i,
  input wire logic [1:0] rd_src_i,
  input wire logic [WADDR_W-1:0] rd_addr_i,
  output logic rd_valid_o,
  output logic rd_denied_o,
  output logic [DATA_W-1:0] rd_data_o,
  input wire logic prog_req_i,
  input wire logic [WADDR_W-1:0] prog_addr_i,
  input wire logic [DATA_W-1:0] prog_data_i,
  input wire logic erase_req_i,
  input wire logic [UNIT_W-1:0] erase_unit_i,
  output logic busy_o,
  output logic done_o,
  input wire logic prot_set_i,
  input wire logic [REGION_W-1:0] prot_region_i,
  input wire logic [1:0] prot_mode_i,
  input wire logic viol_clear_i,
  output logic viol_o
);
  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [DATA_W-1:0] mem_q [ARRAY_WORDS];
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} state_type;
  state_type state_q;
  logic [UNIT_W-1:0] unit_q;
  logic [UOFS_W-1:0] ofs_q;
  logic [WADDR_W-1:0] paddr_q;
  logic [DATA_W-1:0] pdata_q;
  logic rd_valid_q, rd_denied_q, busy_q, done_q, viol_q;
  logic [DATA_W-1:0] rd_data_q;

  function automatic logic [REGION_W-1:0] word_region(input logic [WADDR_W-1:0] a);
    word_region = a[WADDR_W-1 -: REGION_W];
  endfunction

  // ----------------------------------------
  // protection lookups
  // ----------------------------------------
  logic [1:0] rd_mode, wr_mode;
  wire [REGION_W-1:0] wr_region = erase_req_i ? erase_unit_i[UNIT_W-1:1]
                                              : word_region(prog_addr_i);
  flash_prot_table u_rd_table (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(prot_set_i),
    .set_region_i(prot_region_i),
    .set_mode_i(prot_mode_i),
    .look_region_i(word_region(rd_addr_i)),
    .look_mode_o(rd_mode)
  );
  flash_prot_table u_wr_table (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(prot_set_i),
    .set_region_i(prot_region_i),
    .set_mode_i(prot_mode_i),
    .look_region_i(wr_region),
    .look_mode_o(wr_mode)
  );

  wire idle = (state_q == ST_IDLE);
  wire wr_req = idle && (erase_req_i || prog_req_i);
  wire wr_locked = (wr_mode == PROT_READ_ONLY) || (wr_mode == PROT_EXEC_ONLY);
  wire wr_accept = wr_req && !wr_locked;
  wire wr_refuse = wr_req && wr_locked;
  wire rd_locked = (rd_mode == PROT_EXEC_ONLY) && (rd_src_i != SRC_FETCH);
  wire rd_refuse = rd_req_i && rd_locked;
  wire viol_event = wr_refuse || rd_refuse;
  wire erase_last = (state_q == ST_ERASE) && (&ofs_q);
  wire [WADDR_W-1:0] erase_addr = {unit_q, ofs_q};

  // ----------------------------------------
  // erase and program sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      unit_q <= '0;
      ofs_q <= '0;
      paddr_q <= '0;
      pdata_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          ofs_q <= '0;
          if (wr_accept && erase_req_i) begin
            unit_q <= erase_unit_i;
            state_q <= ST_ERASE;
          end else if (wr_accept) begin
            paddr_q <= prog_addr_i;
            pdata_q <= prog_data_i;
            state_q <= ST_PROG;
          end
        end
        ST_ERASE: begin
          ofs_q <= UOFS_W'(ofs_q + 1'b1);
          if (erase_last) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PROG: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // array writes
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (state_q == ST_ERASE) begin
      mem_q[erase_addr] <= ERASED_WORD;
    end else if (state_q == ST_PROG) begin
      mem_q[paddr_q] <= mem_q[paddr_q] & pdata_q;
    end
  end

  // ----------------------------------------
  // reads, status and violation flag
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_q <= 1'b0;
      rd_denied_q <= 1'b0;
      rd_data_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      viol_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_req_i && !rd_locked;
      rd_denied_q <= rd_refuse;
      rd_data_q <= (rd_req_i && !rd_locked) ? mem_q[rd_addr_i] : '0;
      busy_q <= wr_accept || (!idle && !erase_last && state_q != ST_PROG);
      done_q <= erase_last || (state_q == ST_PROG);
      if (viol_event) begin
        viol_q <= 1'b1;
      end else if (viol_clear_i) begin
        viol_q <= 1'b0;
      end
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_denied_o = rd_denied_q;
  assign rd_data_o = rd_data_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign viol_o = viol_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_erase_start;
    idle && erase_req_i && !wr_locked;
  endsequence

  sequence s_prog_start;
    idle && prog_req_i && !erase_req_i && !wr_locked;
  endsequence

  sequence s_prog_finish;
    idle && done_o && !busy_o;
  endsequence

  a_erase_runs_unit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_erase_start |=> (state_q == ST_ERASE) ##(UNIT_WORDS - 1) done_o == 1'b0 ##1 done_o)
    else $error("erase did not finish after one unit");
  a_erase_ones: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_q == ST_ERASE) |=> mem_q[$past(erase_addr)] == ERASED_WORD)
    else $error("erased word not all ones");
  a_ro_refused: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_req && wr_mode == PROT_READ_ONLY) |=> idle && viol_o)
    else $error("read-only region accepted a write");
  a_xo_refused: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_req && wr_mode == PROT_EXEC_ONLY) |=> idle && viol_o)
    else $error("execute-only region accepted a write");
  a_xo_read_deny: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_req_i && rd_mode == PROT_EXEC_ONLY && rd_src_i != SRC_FETCH)
      |=> rd_denied_o && !rd_valid_o && rd_data_o == '0)
    else $error("execute-only data read not denied");
  a_fetch_served: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_req_i && rd_src_i == SRC_FETCH) |=> rd_valid_o && !rd_denied_o)
    else $error("instruction fetch not served");
  a_viol_sticky: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (viol_o && !viol_clear_i) |=> viol_o)
    else $error("violation flag dropped without clear");
  a_region_pair: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (erase_req_i) |-> wr_region == word_region({erase_unit_i, {UOFS_W{1'b0}}}))
    else $error("erase unit mapped to wrong region");
  a_prog_one_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_prog_start |=> ((state_q == ST_PROG) && busy_o) ##1 s_prog_finish)
    else $error("program did not finish in one write cycle");
  a_refuse_untouched: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_refuse |=> idle && !busy_o && !done_o)
    else $error("refused request started a write");
  a_viol_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (viol_event && viol_clear_i) |=> viol_o)
    else $error("clear beat a violation in the same cycle");
  a_open_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_req_i && rd_mode != PROT_EXEC_ONLY) |=> rd_valid_o && !rd_denied_o)
    else $error("read outside execute-only region not served");
  a_done_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_o |=> !done_o)
    else $error("done held longer than one cycle");
endmodule

//--- flash_pkg.sv
package flash_pkg;
  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int unsigned ARRAY_BYTES = 262144;
  localparam int unsigned UNIT_BYTES = 1024;
  localparam int unsigned REGION_BYTES = 2048;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned ARRAY_WORDS = ARRAY_BYTES / WORD_BYTES;
  localparam int unsigned UNIT_WORDS = UNIT_BYTES / WORD_BYTES;
  localparam int unsigned UNIT_COUNT = ARRAY_BYTES / UNIT_BYTES;
  localparam int unsigned REGION_COUNT = ARRAY_BYTES / REGION_BYTES;
  localparam int unsigned WADDR_W = $clog2(ARRAY_WORDS);
  localparam int unsigned UOFS_W = $clog2(UNIT_WORDS);
  localparam int unsigned UNIT_W = $clog2(UNIT_COUNT);
  localparam int unsigned REGION_W = $clog2(REGION_COUNT);
  localparam int unsigned DATA_W = 32;
  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [1:0] PROT_RESET = 2'h0;
  typedef enum logic [1:0] {
    PROT_OPEN,
    PROT_READ_ONLY,
    PROT_EXEC_ONLY,
    PROT_SPARE
  } prot_type;
  typedef enum logic [1:0] {
    SRC_FETCH,
    SRC_DATA,
    SRC_DEBUG,
    SRC_NONE
  } src_type;
endpackage

//--- flash_prot_table.sv
`timescale 1ns/100ps
module flash_prot_table
  import flash_pkg::*;
#(
  parameter int unsigned REGIONS = REGION_COUNT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic [REGION_W-1:0] set_region_i,
  input wire logic [1:0] set_mode_i,
  input wire logic [REGION_W-1:0] look_region_i,
  output logic [1:0] look_mode_o
);
  logic [1:0] mode_q [REGIONS];

  // ----------------------------------------
  // one setting per 2-KB region
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < REGIONS; i++) begin
        mode_q[i] <= PROT_RESET;
      end
    end else if (set_i) begin
      mode_q[set_region_i] <= set_mode_i;
    end
  end

  assign look_mode_o = mode_q[look_region_i];
endmodule

//--- access_agent.sv
`timescale 1ns/100ps
// ----------------------------------------
// processor and debugger read side
// ----------------------------------------
module access_agent
  import flash_pkg::*;
(
  input wire logic sys_clk_i,
  output logic rd_req_o,
  output logic [1:0] rd_src_o,
  output logic [WADDR_W-1:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic rd_denied_i,
  input wire logic [DATA_W-1:0] rd_data_i
);
  initial begin
    rd_req_o = 1'b0;
    rd_src_o = SRC_NONE;
    rd_addr_o = '0;
  end
  // one read; the answer stands in the cycle after the taking edge
  task automatic read(input logic [1:0] src, input logic [WADDR_W-1:0] addr,
                      output logic [1:0] st, output logic [DATA_W-1:0] data);
    @(negedge sys_clk_i);
    rd_req_o = 1'b1;
    rd_src_o = src;
    rd_addr_o = addr;
    @(negedge sys_clk_i);
    rd_req_o = 1'b0;
    rd_src_o = SRC_NONE;
    rd_addr_o = ~addr;
    st = {rd_valid_i, rd_denied_i};
    data = rd_data_i;
  endtask
endmodule

//--- test_flash_block_erase_protect.sv
`timescale 1ns/100ps
module test_flash_block_erase_protect;
  import flash_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, prog_req_i = 0, erase_req_i = 0, prot_set_i = 0;
  logic viol_clear_i = 0, rd_req, rd_valid, rd_denied, busy, done, viol;
  logic [1:0] rd_src, prot_mode = 0;
  logic [WADDR_W-1:0] rd_addr, prog_addr = 0;
  logic [DATA_W-1:0] rd_data, prog_data = 0;
  logic [UNIT_W-1:0] erase_unit = 0;
  logic [REGION_W-1:0] prot_region = 0;
  int err_count = 0, check_count = 0;
  flash_block_erase_protect dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .rd_req_i(rd_req),
    .rd_src_i(rd_src), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_denied_o(rd_denied),
    .rd_data_o(rd_data), .prog_req_i(prog_req_i), .prog_addr_i(prog_addr),
    .prog_data_i(prog_data), .erase_req_i(erase_req_i), .erase_unit_i(erase_unit),
    .busy_o(busy), .done_o(done), .prot_set_i(prot_set_i), .prot_region_i(prot_region),
    .prot_mode_i(prot_mode), .viol_clear_i(viol_clear_i), .viol_o(viol));
  access_agent agent (.sys_clk_i(sys_clk_i), .rd_req_o(rd_req), .rd_src_o(rd_src),
    .rd_addr_o(rd_addr), .rd_valid_i(rd_valid), .rd_denied_i(rd_denied), .rd_data_i(rd_data));
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // erase (er=1) or program one word, then judge busy, done and flag
  task automatic op(input logic er, input logic [WADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic ok);
    int n;
    int nb;
    nb = 0;
    @(negedge sys_clk_i);
    erase_req_i = er;
    prog_req_i = !er;
    erase_unit = a[WADDR_W-1:UOFS_W];
    prog_addr = a;
    prog_data = d;
    @(negedge sys_clk_i);
    erase_req_i = 0;
    prog_req_i = 0;
    chk(viol, !ok);
    for (n = 0; n < 300 && done !== 1'b1; n++) begin
      if (busy === 1'b1) nb++;
      @(negedge sys_clk_i);
    end
    if (ok && done !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    chk(done, ok);
    chk(nb, ok ? (er ? UNIT_WORDS : 1) : 0);
  endtask
  task automatic rd(input logic [1:0] src, input logic [WADDR_W-1:0] a, input logic [1:0] st,
                    input logic [DATA_W-1:0] d);
    logic [1:0] s;
    logic [DATA_W-1:0] v;
    agent.read(src, a, s, v);
    chk(s, st);
    chk(v, st[1] ? d : '0);
  endtask
  task automatic prot(input logic [REGION_W-1:0] r, input logic [1:0] m);
    @(negedge sys_clk_i);
    prot_set_i = 1;
    prot_region = r;
    prot_mode = m;
    @(negedge sys_clk_i);
    prot_set_i = 0;
  endtask
  task automatic clr();
    @(negedge sys_clk_i);
    viol_clear_i = 1;
    @(negedge sys_clk_i);
    viol_clear_i = 0;
    chk(viol, 0);
  endtask
  task automatic t_erase();
    op(1, 16'h0400, '0, 1);
    op(1, 16'h0500, '0, 1);
    op(1, 16'hFF00, '0, 1);
    op(0, 16'h0400, 32'h12345678, 1);
    op(0, 16'h0400, 32'hFFFF00FF, 1);
    op(1, 16'h0500, '0, 1);
    rd(SRC_DATA, 16'h0400, 2'b10, 32'h12340078);
    rd(SRC_DATA, 16'h05FF, 2'b10, ERASED_WORD);
    rd(SRC_DEBUG, 16'hFFFF, 2'b10, ERASED_WORD);
    $display("erase test done");
  endtask
  task automatic t_read_only();
    prot(2, PROT_READ_ONLY);
    op(1, 16'h0600, '0, 1);
    op(0, 16'h0400, '0, 0);
    op(1, 16'h0500, '0, 0);
    rd(SRC_DEBUG, 16'h0400, 2'b10, 32'h12340078);
    rd(SRC_DATA, 16'h05FF, 2'b10, ERASED_WORD);
    clr();
    $display("read-only test done");
  endtask
  task automatic t_exec_only();
    prot(2, PROT_EXEC_ONLY);
    op(1, 16'h0400, '0, 0);
    clr();
    rd(SRC_FETCH, 16'h0400, 2'b10, 32'h12340078);
    chk(viol, 0);
    rd(SRC_DATA, 16'h0400, 2'b01, '0);
    chk(viol, 1);
    rd(SRC_DEBUG, 16'h05FF, 2'b01, '0);
    prot(2, PROT_OPEN);
    clr();
    rd(SRC_DATA, 16'h0400, 2'b10, 32'h12340078);
    $display("execute-only test done");
  endtask
  task automatic t_spare_reset();
    prot(2, PROT_SPARE);
    op(0, 16'h0401, 32'h0000FFFF, 1);
    rd(SRC_DEBUG, 16'h0401, 2'b10, 32'h0000FFFF);
    prot(3, PROT_EXEC_ONLY);
    rd(SRC_DATA, 16'h0600, 2'b01, '0);
    @(negedge sys_clk_i);
    rst_i = 1;
    @(negedge sys_clk_i);
    rst_i = 0;
    chk({busy, done, viol, rd_valid, rd_denied}, '0);
    rd(SRC_DATA, 16'h0600, 2'b10, ERASED_WORD);
    $display("spare mode and reset test done");
  endtask
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_i = 0;
    chk({busy, done, viol, rd_valid, rd_denied}, '0);
    t_erase();
    t_read_only();
    t_exec_only();
    t_spare_reset();
    wrap_up();
  end
endmodule
